// ===== include/scr_consts.vh
// constants for the synthesizer control register bank
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH

// ----------------------------------------
// word and select field
// ----------------------------------------
`define SCR_WORD_W 32
`define SCR_SEL_HI 2
`define SCR_SEL_LO 0
`define SCR_SEL_REG0 3'h0
`define SCR_SEL_REG2 3'h2
`define SCR_SEL_REG3 3'h3
`define SCR_SEL_REG4 3'h4
`define SCR_SEL_REG5 3'h5
`define SCR_REG_RST 32'h0000_0000

// ----------------------------------------
// divider_and_pump_control fields
// ----------------------------------------
`define SCR_R2_DBUF 13
`define SCR_R2_CP_TRI 4
`define SCR_R2_CNT_RST 3

// ----------------------------------------
// loop_timing_control fields
// ----------------------------------------
`define SCR_R3_BS_FAST 23
`define SCR_R3_BACKLASH 22
`define SCR_R3_CHG_CANCEL 21
`define SCR_R3_SLIP_RED 18
`define SCR_R3_CDM_HI 16
`define SCR_R3_CDM_LO 15
`define SCR_R3_CDIV_HI 14
`define SCR_R3_CDIV_LO 3
`define SCR_CDM_OFF 2'h0
`define SCR_CDM_FAST 2'h1
`define SCR_CDM_RESYNC 2'h2

// ----------------------------------------
// output_path_control fields
// ----------------------------------------
`define SCR_R4_FB_VCO 23
`define SCR_R4_RFDIV_HI 22
`define SCR_R4_RFDIV_LO 20
`define SCR_R4_BSDIV_HI 19
`define SCR_R4_BSDIV_LO 12
`define SCR_R4_VCO_PD 11
`define SCR_R4_MUTE_LOCK 10
`define SCR_R4_AUX_VCO 9
`define SCR_R4_AUX_EN 8
`define SCR_R4_AUX_PWR_HI 7
`define SCR_R4_AUX_PWR_LO 6
`define SCR_R4_RF_EN 5
`define SCR_R4_RF_PWR_HI 4
`define SCR_R4_RF_PWR_LO 3

// ----------------------------------------
// lock_pin_control fields
// ----------------------------------------
`define SCR_R5_LDPIN_HI 23
`define SCR_R5_LDPIN_LO 22

`endif

// ===== rtl/scr_shift.v
// three-wire serial word receiver
`timescale 1ns/1ps
`include "scr_consts.vh"

module scr_shift (
	input wire ref_clk,
	input wire rst,
	input wire ser_clk,
	input wire ser_data,
	input wire ser_le,
	output reg [`SCR_WORD_W-1:0] word_q,
	output reg word_valid_q
);

	reg [`SCR_WORD_W-1:0] shift_q;
	reg clk_prev_q;
	reg le_prev_q;

	// ----------------------------------------
	// msb first, latch on load-enable rise
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			shift_q <= `SCR_REG_RST;
			word_q <= `SCR_REG_RST;
			clk_prev_q <= 1'b0;
			le_prev_q <= 1'b0;
			word_valid_q <= 1'b0;
		end
		else
		begin
			clk_prev_q <= ser_clk;
			le_prev_q <= ser_le;
			word_valid_q <= ser_le & ~le_prev_q;
			if (ser_clk && !clk_prev_q)
				shift_q <= {shift_q[`SCR_WORD_W-2:0], ser_data};
			if (ser_le && !le_prev_q)
				word_q <= shift_q;
		end
	end

endmodule // scr_shift

// ===== rtl/scr_timeout.v
// clock divider timeout counter for fast lock and phase resync
`timescale 1ns/1ps
`include "scr_consts.vh"

module scr_timeout (
	input wire ref_clk,
	input wire rst,
	input wire [1:0] mode,
	input wire [11:0] limit,
	input wire start,
	input wire pfd_tick,
	output reg fast_lock_q,
	output reg resync_q
);

	reg [11:0] cnt_q;
	reg run_q;

	// ----------------------------------------
	// count phase detector cycles
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 12'h000;
			run_q <= 1'b0;
			fast_lock_q <= 1'b0;
			resync_q <= 1'b0;
		end
		else
		begin
			resync_q <= 1'b0;
			if (mode == `SCR_CDM_OFF)
				run_q <= 1'b0;
			else if (start)
			begin
				cnt_q <= limit;
				run_q <= 1'b1;
			end
			else if (run_q && pfd_tick)
			begin
				// a limit of zero ends on the first tick
				if (cnt_q <= 12'h001)
				begin
					run_q <= 1'b0;
					resync_q <= (mode == `SCR_CDM_RESYNC);
				end
				else
					cnt_q <= cnt_q - 12'h001;
			end
			fast_lock_q <= run_q & (mode == `SCR_CDM_FAST) & ~(pfd_tick & cnt_q <= 12'h001);
		end
	end

endmodule // scr_timeout

// ===== rtl/scr_regs.v
// write-only control register bank of the fractional-n synthesizer
//
// Overview of operation
// - charge pump tri-state bit high puts pump output in high impedance.
// - counter reset bit high holds reference and feedback dividers in reset.
// - select bits 011, 100, 101 steer a word to registers 3, 4, 5.
// - band-select mode bit picks faster sequence; host keeps divider at most 254.
// - backlash width select gives 6 ns when low, 3 ns when high.
// - charge-cancel bit enables cancellation; host clears it in fractional mode.
// - slip-reduction bit enables it; host supplies 50% duty and minimum current.
// - clock divider mode 10 resync, 01 fast lock, 00 disabled.
// - twelve-bit divider value is timeout for resync and fast lock.
// - feedback select high takes vco directly, low takes output divider.
// - three-bit field picks the rf output divider ratio.
// - eight-bit field divides reference counter output to clock band select.
// - vco power-down bit low powers up, high powers down.
// - mute-until-locked keeps rf output unpowered until digital lock.
// - aux source low takes rf divider output, high the vco.
// - aux enable low disables, high enables the auxiliary output.
// - primary enable low disables, high enables the primary output.
// - two-bit fields set aux and primary output power levels.
// - two-bit field in register 5 picks lock indicator pin function.
// - double-buffer bit holds divider select until register 0 is written.
`timescale 1ns/1ps
`include "scr_consts.vh"

module scr_regs (
	input wire ref_clk,
	input wire rst,
	input wire ser_clk,
	input wire ser_data,
	input wire ser_le,
	input wire ref_div_tick,
	input wire pfd_tick,
	input wire digital_lock,
	input wire [3:0] lock_func_src,
	output reg cp_three_state,
	output reg counters_reset,
	output reg band_select_fast,
	output reg backlash_pulse_width_select,
	output reg charge_cancel_enable,
	output reg slip_reduction_enable,
	output reg [1:0] clk_div_mode,
	output reg [11:0] clk_div_value,
	output wire fast_lock_active,
	output wire resync_fire,
	output reg feedback_from_vco,
	output reg [2:0] rf_div_sel,
	output reg [7:0] band_clk_div,
	output reg band_clk_tick,
	output reg vco_power_down,
	output reg rf_stage_powered,
	output reg aux_out_from_vco,
	output reg aux_out_enable,
	output reg [1:0] aux_power,
	output reg rf_out_enable,
	output reg [1:0] rf_power,
	output reg [1:0] lock_indicator_sel,
	output reg lock_indicator_pin
);

	// ----------------------------------------
	// select decode
	// ----------------------------------------
	function scr_is_sel;
		input [`SCR_WORD_W-1:0] word;
		input [2:0] code;
		begin
			scr_is_sel = (word[`SCR_SEL_HI:`SCR_SEL_LO] == code);
		end
	endfunction

	wire [`SCR_WORD_W-1:0] rx_word;
	wire rx_valid;
	wire wr_reg0;
	wire wr_reg4;
	wire dbuf_on;
	wire [`SCR_WORD_W-1:0] r2_q;
	wire [`SCR_WORD_W-1:0] r3_q;
	wire [`SCR_WORD_W-1:0] r4_q;
	wire [`SCR_WORD_W-1:0] r5_q;
	reg [7:0] bs_cnt_q;
	reg [7:0] bs_cnt_d;
	reg bs_wrap;
	reg [7:0] bs_limit;

	// ----------------------------------------
	// serial receiver
	// ----------------------------------------
	scr_shift u_shift (
		.ref_clk(ref_clk),
		.rst(rst),
		.ser_clk(ser_clk),
		.ser_data(ser_data),
		.ser_le(ser_le),
		.word_q(rx_word),
		.word_valid_q(rx_valid)
	);

	// ----------------------------------------
	// register bank, one word per select code 2 to 5
	// ----------------------------------------
	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1)
		begin : g_reg
			reg [`SCR_WORD_W-1:0] q;
			always @(posedge ref_clk or posedge rst)
			begin
				if (rst)
					q <= `SCR_REG_RST;
				else if (rx_valid && scr_is_sel(rx_word, `SCR_SEL_REG2 + k))
					q <= rx_word;
			end
		end
	endgenerate

	assign r2_q = g_reg[0].q;
	assign r3_q = g_reg[1].q;
	assign r4_q = g_reg[2].q;
	assign r5_q = g_reg[3].q;

	// registers 0 and 1 are not held here; a register 0 write is an update event
	assign wr_reg0 = rx_valid & scr_is_sel(rx_word, `SCR_SEL_REG0);
	assign wr_reg4 = rx_valid & scr_is_sel(rx_word, `SCR_SEL_REG4);
	assign dbuf_on = r2_q[`SCR_R2_DBUF];

	// ----------------------------------------
	// pump and counter controls
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cp_three_state <= 1'b0;
			counters_reset <= 1'b0;
		end
		else
		begin
			cp_three_state <= r2_q[`SCR_R2_CP_TRI];
			counters_reset <= r2_q[`SCR_R2_CNT_RST];
		end
	end

	// ----------------------------------------
	// loop timing controls
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			band_select_fast <= 1'b0;
			backlash_pulse_width_select <= 1'b0;
			charge_cancel_enable <= 1'b0;
			slip_reduction_enable <= 1'b0;
			clk_div_mode <= `SCR_CDM_OFF;
			clk_div_value <= 12'h000;
		end
		else
		begin
			band_select_fast <= r3_q[`SCR_R3_BS_FAST];
			backlash_pulse_width_select <= r3_q[`SCR_R3_BACKLASH];
			charge_cancel_enable <= r3_q[`SCR_R3_CHG_CANCEL];
			slip_reduction_enable <= r3_q[`SCR_R3_SLIP_RED];
			clk_div_mode <= r3_q[`SCR_R3_CDM_HI:`SCR_R3_CDM_LO];
			clk_div_value <= r3_q[`SCR_R3_CDIV_HI:`SCR_R3_CDIV_LO];
		end
	end

	// ----------------------------------------
	// fast lock and resync timeout
	// ----------------------------------------
	// the timer restarts on every register 0 write, the frequency update event, unless clk_div_mode is 00
	scr_timeout u_timeout (
		.ref_clk(ref_clk),
		.rst(rst),
		.mode(clk_div_mode),
		.limit(clk_div_value),
		.start(wr_reg0),
		.pfd_tick(pfd_tick),
		.fast_lock_q(fast_lock_active),
		.resync_q(resync_fire)
	);

	// ----------------------------------------
	// output divider select with double buffer
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rf_div_sel <= 3'h0;
		else if (wr_reg4 && !dbuf_on)
			rf_div_sel <= rx_word[`SCR_R4_RFDIV_HI:`SCR_R4_RFDIV_LO];
		else if (wr_reg0)
			rf_div_sel <= r4_q[`SCR_R4_RFDIV_HI:`SCR_R4_RFDIV_LO];
	end

	// ----------------------------------------
	// output path controls
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			feedback_from_vco <= 1'b0;
			band_clk_div <= 8'h00;
			vco_power_down <= 1'b0;
			rf_stage_powered <= 1'b0;
			aux_out_from_vco <= 1'b0;
			aux_out_enable <= 1'b0;
			aux_power <= 2'h0;
			rf_out_enable <= 1'b0;
			rf_power <= 2'h0;
		end
		else
		begin
			feedback_from_vco <= r4_q[`SCR_R4_FB_VCO];
			band_clk_div <= r4_q[`SCR_R4_BSDIV_HI:`SCR_R4_BSDIV_LO];
			vco_power_down <= r4_q[`SCR_R4_VCO_PD];
			// stage stays off while muted and not yet locked
			rf_stage_powered <= ~(r4_q[`SCR_R4_MUTE_LOCK] & ~digital_lock);
			aux_out_from_vco <= r4_q[`SCR_R4_AUX_VCO];
			aux_out_enable <= r4_q[`SCR_R4_AUX_EN];
			aux_power <= r4_q[`SCR_R4_AUX_PWR_HI:`SCR_R4_AUX_PWR_LO];
			rf_out_enable <= r4_q[`SCR_R4_RF_EN];
			rf_power <= r4_q[`SCR_R4_RF_PWR_HI:`SCR_R4_RF_PWR_LO];
		end
	end

	// ----------------------------------------
	// band select clock divider
	// ----------------------------------------
	// a divider value of zero is treated as one so the clock never stops
	always @*
	begin
		bs_limit = (band_clk_div == 8'h00) ? 8'h01 : band_clk_div;
		bs_wrap = 1'b0;
		bs_cnt_d = bs_cnt_q;
		if (ref_div_tick)
		begin
			if (bs_cnt_q + 8'h01 >= bs_limit)
			begin
				bs_wrap = 1'b1;
				bs_cnt_d = 8'h00;
			end
			else
				bs_cnt_d = bs_cnt_q + 8'h01;
		end
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bs_cnt_q <= 8'h00;
			band_clk_tick <= 1'b0;
		end
		else
		begin
			bs_cnt_q <= bs_cnt_d;
			band_clk_tick <= bs_wrap;
		end
	end

	// ----------------------------------------
	// lock indicator pin
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			lock_indicator_sel <= 2'h0;
			lock_indicator_pin <= 1'b0;
		end
		else
		begin
			lock_indicator_sel <= r5_q[`SCR_R5_LDPIN_HI:`SCR_R5_LDPIN_LO];
			lock_indicator_pin <= lock_func_src[r5_q[`SCR_R5_LDPIN_HI:`SCR_R5_LDPIN_LO]];
		end
	end

endmodule // scr_regs

// ===== tb/scr_chk.sv
// checker for the control register bank ports
`timescale 1ns/1ps
module scr_chk (
	input wire ref_clk,
	input wire rst,
	input wire ser_le,
	input wire ref_div_tick,
	input wire pfd_tick,
	input wire digital_lock,
	input wire [3:0] lock_func_src,
	input wire [1:0] clk_div_mode,
	input wire fast_lock_active,
	input wire resync_fire,
	input wire [2:0] rf_div_sel,
	input wire band_clk_tick,
	input wire rf_stage_powered,
	input wire [1:0] lock_indicator_sel,
	input wire lock_indicator_pin
);
	reg le_q;
	reg [2:0] since_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----
	// cycles since a load strobe
	// ----
	// saturates so that far-off changes never look like loads
	always @(posedge ref_clk or posedge rst)
		if (rst)
		begin
			le_q <= 1'b0;
			since_q <= 3'h7;
		end
		else
		begin
			le_q <= ser_le;
			if (ser_le && !le_q)
				since_q <= 3'h0;
			else if (since_q != 3'h7)
				since_q <= since_q + 3'h1;
		end
	// ----
	// properties
	// ----
	lock_power_a: assert property ($past(digital_lock) && !$past(rst) |-> rf_stage_powered)
		else $error("rf stage off while locked");
	pin_src_a: assert property (($stable(lock_func_src) && $stable(lock_indicator_sel)) [*3]
		|-> lock_indicator_pin == lock_func_src[lock_indicator_sel]) else $error("lock pin");
	fast_start_a: assert property ($rose(fast_lock_active) |-> clk_div_mode == 2'h1
		&& since_q inside {[2:5]}) else $error("fast lock start");
	fast_end_a: assert property ($fell(fast_lock_active) && since_q == 3'h7 |-> $past(pfd_tick))
		else $error("fast lock end");
	resync_src_a: assert property (resync_fire |-> clk_div_mode == 2'h2 && $past(pfd_tick))
		else $error("resync cause");
	resync_one_a: assert property (resync_fire |=> !resync_fire)
		else $error("resync width");
	band_tick_a: assert property (band_clk_tick |-> $past(ref_div_tick))
		else $error("band tick cause");
	field_time_a: assert property (!$stable({clk_div_mode, lock_indicator_sel})
		|-> since_q inside {[2:4]}) else $error("field moved off load");
	// the divider select is taken from the received word, or from register 4 on a register 0 write, one stage earlier
	div_sel_time_a: assert property (!$stable(rf_div_sel) |-> since_q == 3'h1)
		else $error("divider select moved off load");
	cover property ($rose(fast_lock_active));
	cover property (resync_fire);
	cover property (band_clk_tick);
	cover property (lock_indicator_pin);
endmodule // scr_chk

// ===== tb/scr_host.sv
// host model driving the three-wire load interface
`timescale 1ns/1ps
module scr_host (
	input wire ref_clk,
	output reg ser_clk,
	output reg ser_data,
	output reg ser_le
);
	integer i;
	initial
	begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_le = 1'b0;
	end
	// levels last two cycles, above the one-cycle minimum
	// callers pass whole words in load order, divider fields in legal ranges
	task send(input [31:0] w);
		begin
			for (i = 31; i >= 0; i = i - 1)
			begin
				@(posedge ref_clk);
				ser_clk <= 1'b0;
				ser_data <= w[i];
				repeat (2) @(posedge ref_clk);
				ser_clk <= 1'b1;
				@(posedge ref_clk);
			end
			@(posedge ref_clk);
			ser_clk <= 1'b0;
			ser_data <= ~w[0];
			repeat (2) @(posedge ref_clk);
			ser_le <= 1'b1;
			repeat (2) @(posedge ref_clk);
			ser_le <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask
endmodule // scr_host

// ===== tb/scr_regs_tb.sv
// testbench for the control register bank
`timescale 1ns/1ps
module scr_regs_tb;
	reg ref_clk, rst, ref_div_tick, pfd_tick, digital_lock;
	reg [3:0] lock_func_src;
	wire ser_clk, ser_data, ser_le, cp_three_state, counters_reset, band_select_fast;
	wire backlash_pulse_width_select, charge_cancel_enable, slip_reduction_enable;
	wire fast_lock_active, resync_fire, feedback_from_vco, band_clk_tick, vco_power_down;
	wire rf_stage_powered, aux_out_from_vco, aux_out_enable, rf_out_enable, lock_indicator_pin;
	wire [1:0] clk_div_mode, aux_power, rf_power, lock_indicator_sel;
	wire [11:0] clk_div_value;
	wire [2:0] rf_div_sel;
	wire [7:0] band_clk_div;
	integer err_total, compares, n, ticks;
	reg [31:0] w4;
	scr_host host (.ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));
	scr_regs dut (.ref_clk(ref_clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
		.ser_le(ser_le), .ref_div_tick(ref_div_tick), .pfd_tick(pfd_tick),
		.digital_lock(digital_lock), .lock_func_src(lock_func_src),
		.cp_three_state(cp_three_state), .counters_reset(counters_reset),
		.band_select_fast(band_select_fast),
		.backlash_pulse_width_select(backlash_pulse_width_select),
		.charge_cancel_enable(charge_cancel_enable),
		.slip_reduction_enable(slip_reduction_enable), .clk_div_mode(clk_div_mode),
		.clk_div_value(clk_div_value), .fast_lock_active(fast_lock_active),
		.resync_fire(resync_fire), .feedback_from_vco(feedback_from_vco),
		.rf_div_sel(rf_div_sel), .band_clk_div(band_clk_div), .band_clk_tick(band_clk_tick),
		.vco_power_down(vco_power_down), .rf_stage_powered(rf_stage_powered),
		.aux_out_from_vco(aux_out_from_vco), .aux_out_enable(aux_out_enable),
		.aux_power(aux_power), .rf_out_enable(rf_out_enable), .rf_power(rf_power),
		.lock_indicator_sel(lock_indicator_sel), .lock_indicator_pin(lock_indicator_pin));
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (band_clk_tick)
			ticks <= ticks + 1;
	// ----
	// tasks
	// ----
	task chk(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp)
			begin
				err_total = err_total + 1;
				$display("[ERR] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	// detector ticks stay sparse, well inside the host's rate limits
	task tick(input integer k, input reg phase_frequency_detector);
		repeat (k)
		begin
			@(posedge ref_clk);
			pfd_tick <= phase_frequency_detector;
			ref_div_tick <= !phase_frequency_detector;
			@(posedge ref_clk);
			pfd_tick <= 1'b0;
			ref_div_tick <= 1'b0;
		end
	endtask
	task print_verdict;
		begin
			$display("compares %0d err_total %0d", compares, err_total);
			if (err_total == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial
	begin
		#400_000;
		err_total = err_total + 1;
		print_verdict;
	end
	// ----
	// sequence
	// ----
	initial
	begin
		{rst, ref_div_tick, pfd_tick, digital_lock, lock_func_src} = 8'h80;
		{err_total, compares, ticks} = 0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({cp_three_state, counters_reset, clk_div_value, rf_div_sel, band_clk_div}, 0);
		chk(rf_stage_powered, 1);
		for (n = 0; n < 4; n = n + 1)
		begin
			host.send({8'h00, n[1:0], 22'h00_0005});
			lock_func_src <= 4'h1 << n;
			repeat (3) @(posedge ref_clk);
			chk({lock_indicator_sel, lock_indicator_pin}, {n[1:0], 1'b1});
			lock_func_src <= ~(4'h1 << n);
			repeat (3) @(posedge ref_clk);
			chk(lock_indicator_pin, 0);
		end
		w4 = 32'h00D0_3BAC;
		host.send(w4);
		chk({feedback_from_vco, rf_div_sel, band_clk_div, vco_power_down}, w4[23:11]);
		chk({aux_out_from_vco, aux_out_enable, aux_power, rf_out_enable, rf_power}, w4[9:3]);
		tick(6, 0);
		repeat (2) @(posedge ref_clk);
		chk(ticks, 2);
		host.send(32'h00C4_801B);
		chk({band_select_fast, backlash_pulse_width_select, charge_cancel_enable,
			slip_reduction_enable, clk_div_mode, clk_div_value}, 18'h3_5003);
		host.send(32'h0000_001A);
		chk({cp_three_state, counters_reset, rf_div_sel}, 5'h1D);
		// code 1 has no register here, so the word must vanish
		host.send(32'hFFFF_FFF9);
		chk({cp_three_state, counters_reset, rf_div_sel, clk_div_mode}, 7'h75);
		host.send(32'h0000_0000);
		chk(fast_lock_active, 1);
		tick(2, 1);
		#1 chk(fast_lock_active, 1);
		tick(1, 1);
		#1 chk(fast_lock_active, 0);
		host.send(32'h00C5_0013);
		host.send(32'h0000_2002);
		chk({cp_three_state, counters_reset}, 0);
		host.send(32'h00A0_3BAC);
		chk(rf_div_sel, 3'h5);
		host.send(32'h0000_0000);
		chk(rf_div_sel, 3'h2);
		tick(2, 1);
		#1 chk(resync_fire, 1);
		host.send(32'h00A0_3FAC);
		chk(rf_stage_powered, 0);
		digital_lock <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(rf_stage_powered, 1);
		print_verdict;
	end
endmodule // scr_regs_tb
bind scr_regs scr_chk chk_i (.ref_clk(ref_clk), .rst(rst), .ser_le(ser_le),
	.ref_div_tick(ref_div_tick), .pfd_tick(pfd_tick), .digital_lock(digital_lock),
	.lock_func_src(lock_func_src), .clk_div_mode(clk_div_mode),
	.fast_lock_active(fast_lock_active), .resync_fire(resync_fire), .rf_div_sel(rf_div_sel),
	.band_clk_tick(band_clk_tick), .rf_stage_powered(rf_stage_powered),
	.lock_indicator_sel(lock_indicator_sel), .lock_indicator_pin(lock_indicator_pin));
